// file: design/radio_cfg.svh
`ifndef RADIO_CFG_SVH
`define RADIO_CFG_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define RSM_CFG_ADDR      6'h18
`define RSM_CFG_RESET     8'h04
// ----------------------------------------
// field positions
// ----------------------------------------
`define AUTOCAL_HI        5
`define AUTOCAL_LO        4
`define PO_SEL_HI         3
`define PO_SEL_LO         2
`define PIN_CTRL_BIT      1
`define XTAL_KEEP_BIT     0
`define CFG_WMASK         8'h3F
// ----------------------------------------
// power-on expiry counts
// ----------------------------------------
`define RIPPLE_MAX        6'h3F
`define EXPIRE_SEL0       9'h001
`define EXPIRE_SEL1       9'h010
`define EXPIRE_SEL2       9'h040
`define EXPIRE_SEL3       9'h100
`endif

// file: design/radio_pkg.sv
package radio_pkg;
  typedef enum logic [1:0] {
    CAL_NEVER,
    CAL_FROM_IDLE,
    CAL_TO_IDLE,
    CAL_FOURTH_TO_IDLE
  } autocal_e;
  typedef enum logic [1:0] {
    PWR_WAIT_XTAL,
    PWR_COUNT,
    PWR_READY
  } pwr_state_e;
endpackage

// file: design/radio_state_autocal_timeout_config.sv
// Notes on behaviour
// R01 - autocal 00: calibrate only when the manual calibrate strobe arrives.
// R02 - autocal 01: calibrate on idle to receive, transmit or synth-on.
// R03 - autocal 10: calibrate on each automatic return to idle.
// R04 - autocal 11: calibrate on every fourth automatic return, two-bit count.
// R05 - after crystal stable, wait selected ripple expiries, then chip ready low.
// R06 - expire select 0..3 gives 1, 16, 64, 256 ripple expiries.
// R07 - timeout counted in crystal clock cycles, scales with crystal.
// R08 - software should pick expire select 2 for robust operation.
// R09 - with crystal off in power-down, software may pick select 0.
// R10 - pin control enable bit 1 allows radio state control from pins.
// R11 - crystal keep-on bit 0 keeps crystal running in sleep.
// R12 - fields live in register at address 0x18.
`include "radio_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module radio_state_autocal_timeout_config (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [5:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       xtal_stable_i,
  input  wire logic       idle_to_active_i,
  input  wire logic       auto_return_idle_i,
  input  wire logic       synth_calibrate_strobe_i,
  input  wire logic       sleep_state_i,
  output logic            synth_cal_start_o,
  output logic            chip_ready_low_o,
  output logic            pin_ctrl_en_o,
  output logic            crystal_run_o
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic xs_meta_q;
  logic xs_q;
  // stable flag comes from the analogue oscillator detector
  // only the second flop feeds logic; the first may still be settling
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      xs_meta_q <= 1'b0;
      xs_q      <= 1'b0;
    end
    else
    begin
      xs_meta_q <= xtal_stable_i;
      xs_q      <= xs_meta_q;
    end
  end
  // ----------------------------------------
  // configuration register
  // ----------------------------------------
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  wire        cfg_hit = (reg_addr_i == `RSM_CFG_ADDR); // [R12]
  wire        cfg_wr  = reg_wr_i && cfg_hit;
  // top two bits are unused and read as zero
  assign cfg_d = cfg_wr ? (reg_wdata_i & `CFG_WMASK) : cfg_q;
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cfg_q <= `RSM_CFG_RESET;
    else
      cfg_q <= cfg_d;
  end
  // read path is combinational, so a read needs no wait state
  // unmapped addresses read zero
  assign reg_rdata_o = cfg_hit ? cfg_q : 8'h00;
  // ----------------------------------------
  // field decode
  // ----------------------------------------
  radio_pkg::autocal_e autocal_sel;
  wire [1:0] po_sel = cfg_q[`PO_SEL_HI:`PO_SEL_LO];
  assign autocal_sel   = radio_pkg::autocal_e'(cfg_q[`AUTOCAL_HI:`AUTOCAL_LO]);
  assign pin_ctrl_en_o = cfg_q[`PIN_CTRL_BIT]; // [R10]
  // oscillator stops in sleep unless forced on
  assign crystal_run_o = !sleep_state_i || cfg_q[`XTAL_KEEP_BIT]; // [R11]
  // ----------------------------------------
  // calibration trigger
  // ----------------------------------------
  logic [1:0] ret_cnt_q;
  logic [1:0] ret_cnt_d;
  logic       auto_cal;
  // returns advance the count in every mode, so mode 11 phase carries history
  // count wraps so the fourth return lands on 3
  assign ret_cnt_d = auto_return_idle_i ? ret_cnt_q + 2'h1 : ret_cnt_q; // [R04]
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ret_cnt_q <= 2'h0;
    else
      ret_cnt_q <= ret_cnt_d;
  end
  always_comb
  begin
    unique case (autocal_sel)
      radio_pkg::CAL_NEVER:          auto_cal = 1'b0;                 // [R01]
      radio_pkg::CAL_FROM_IDLE:      auto_cal = idle_to_active_i;     // [R02]
      radio_pkg::CAL_TO_IDLE:        auto_cal = auto_return_idle_i;   // [R03]
      radio_pkg::CAL_FOURTH_TO_IDLE: auto_cal = auto_return_idle_i
                                                && (ret_cnt_q == 2'h3); // [R04]
    endcase
  end
  // manual strobe always works, in every mode
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      synth_cal_start_o <= 1'b0;
    else
      synth_cal_start_o <= auto_cal || synth_calibrate_strobe_i; // [R01]
  end
  // ----------------------------------------
  // power-on timeout
  // ----------------------------------------
  radio_pkg::pwr_state_e pst_q;
  radio_pkg::pwr_state_e pst_d;
  logic [5:0] ripple_q;
  logic [8:0] expire_q;
  logic [8:0] expire_target;
  wire        ripple_done = (ripple_q == `RIPPLE_MAX);
  // expiry count tracks the live select, counted in 64-cycle ripple expiries
  assign expire_target = (po_sel == 2'h0) ? `EXPIRE_SEL0 :
                         (po_sel == 2'h1) ? `EXPIRE_SEL1 :
                         (po_sel == 2'h2) ? `EXPIRE_SEL2 : `EXPIRE_SEL3; // [R06]
  // a select lowered mid-count ends the wait at the next ripple expiry instead of
  // wrapping the expiry count, which would stretch it to 512 expiries
  wire last_expire = ripple_done && (expire_q + 9'h001 >= expire_target);
  always_comb
  begin
    pst_d = pst_q;
    unique case (pst_q)
      radio_pkg::PWR_WAIT_XTAL: if (xs_q) pst_d = radio_pkg::PWR_COUNT;
      radio_pkg::PWR_COUNT:
        if (!xs_q)
          pst_d = radio_pkg::PWR_WAIT_XTAL;
        else if (last_expire)
          pst_d = radio_pkg::PWR_READY; // [R05]
      radio_pkg::PWR_READY: if (!xs_q) pst_d = radio_pkg::PWR_WAIT_XTAL;
      default:              pst_d = radio_pkg::PWR_WAIT_XTAL; // unused code
    endcase
  end
  // ripple counter runs on the crystal clock, so delay scales with it
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pst_q    <= radio_pkg::PWR_WAIT_XTAL;
      ripple_q <= 6'h00;
      expire_q <= 9'h000;
    end
    else
    begin
      pst_q <= pst_d;
      if (pst_q != radio_pkg::PWR_COUNT)
      begin
        ripple_q <= 6'h00;
        expire_q <= 9'h000;
      end
      else
      begin
        ripple_q <= ripple_q + 6'h01; // [R07]
        if (ripple_done)
          expire_q <= expire_q + 9'h001;
      end
    end
  end
  // active low, and held high until timeout has run out
  // taken from the next state so the pin moves with the state, not a cycle late
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      chip_ready_low_o <= 1'b1;
    else
      chip_ready_low_o <= (pst_d != radio_pkg::PWR_READY); // [R05]
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // calibration trigger
  never_cal_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R01]
    (autocal_sel == radio_pkg::CAL_NEVER && !synth_calibrate_strobe_i)
    |=> !synth_cal_start_o) else $error("calibration without strobe");
  cal_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R01]
    (!auto_cal && !synth_calibrate_strobe_i) |=> !synth_cal_start_o)
    else $error("calibration pulse without cause");
  from_idle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R02]
    (autocal_sel == radio_pkg::CAL_FROM_IDLE && idle_to_active_i)
    |=> synth_cal_start_o) else $error("no cal leaving idle");
  to_idle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R03]
    (autocal_sel == radio_pkg::CAL_TO_IDLE && auto_return_idle_i)
    |=> synth_cal_start_o) else $error("no cal on return");
  fourth_ret_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R04]
    (autocal_sel == radio_pkg::CAL_FOURTH_TO_IDLE && auto_return_idle_i
     && !synth_calibrate_strobe_i)
    |=> synth_cal_start_o == ($past(ret_cnt_q) == 2'h3)) else $error("fourth return");
  ret_count_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R04]
    auto_return_idle_i |=> ret_cnt_q == $past(ret_cnt_q) + 2'h1)
    else $error("return count skipped");
  // power-on timeout
  ready_wait_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R05]
    $fell(chip_ready_low_o) |-> $past(xs_q, 64)) else $error("ready too early");
  ready_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R05]
    (pst_q == radio_pkg::PWR_READY) |-> !chip_ready_low_o)
    else $error("ready not shown");
  expire_step_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R05]
    (pst_q == radio_pkg::PWR_COUNT && pst_d == radio_pkg::PWR_COUNT && ripple_done)
    |=> expire_q == $past(expire_q) + 9'h001) else $error("expiry not counted");
  expire_map_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R06]
    (po_sel == 2'h2) |-> expire_target == 9'h040) else $error("bad expiry map");
  ripple_step_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R07]
    (pst_q == radio_pkg::PWR_COUNT && pst_d == radio_pkg::PWR_COUNT)
    |=> ripple_q == $past(ripple_q) + 6'h01) else $error("ripple stalled");
  // register fields
  pin_ctrl_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R10]
    cfg_wr |=> pin_ctrl_en_o == $past(reg_wdata_i[`PIN_CTRL_BIT]))
    else $error("pin enable not written");
  keep_on_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R11]
    sleep_state_i && cfg_q[`XTAL_KEEP_BIT] |-> crystal_run_o) else $error("crystal stopped");
  addr_map_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R12]
    reg_wr_i && reg_addr_i != `RSM_CFG_ADDR |=> $stable(cfg_q)) else $error("stray write");
endmodule
`default_nettype wire

// file: sim/radio_state_autocal_timeout_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
module radio_state_autocal_timeout_config_bench;
  // ----------------------------------------
  // stimulus and bookkeeping
  // ----------------------------------------
  logic       clk_i                    = 1'b0;
  logic       rst_b_i                  = 1'b0;
  logic [5:0] reg_addr_i               = 6'h18;
  logic       reg_wr_i                 = 1'b0;
  logic [7:0] reg_wdata_i              = 8'h00;
  logic       xtal_stable_i            = 1'b0;
  logic       idle_to_active_i         = 1'b0;
  logic       auto_return_idle_i       = 1'b0;
  logic       synth_calibrate_strobe_i = 1'b0;
  logic       sleep_state_i            = 1'b0;
  wire  [7:0] reg_rdata_o;
  wire        synth_cal_start_o;
  wire        chip_ready_low_o;
  wire        pin_ctrl_en_o;
  wire        crystal_run_o;
  int         fail_count               = 0;
  int         checks_done              = 0;
  int         ret_n                    = 0;  // returns counted in every mode, so track all
  int         exp_tab [4]              = '{1, 16, 64, 256};

  // 10 MHz crystal clock
  always #50 clk_i = ~clk_i;

  radio_state_autocal_timeout_config u_radio_state_autocal_timeout_config (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .xtal_stable_i(xtal_stable_i),
    .idle_to_active_i(idle_to_active_i), .auto_return_idle_i(auto_return_idle_i),
    .synth_calibrate_strobe_i(synth_calibrate_strobe_i), .sleep_state_i(sleep_state_i),
    .synth_cal_start_o(synth_cal_start_o), .chip_ready_low_o(chip_ready_low_o),
    .pin_ctrl_en_o(pin_ctrl_en_o), .crystal_run_o(crystal_run_o));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // one-cycle write strobe, address parked back on the config register
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wr_i    <= 1'b1;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i   <= 1'b0;
    reg_addr_i <= 6'h18;
    #1;
  endtask

  // one-cycle event: 0 leave idle, 1 auto return, 2 manual strobe
  task automatic fire(input int which, output logic cal);
    @(posedge clk_i);
    idle_to_active_i         <= (which == 0);
    auto_return_idle_i       <= (which == 1);
    synth_calibrate_strobe_i <= (which == 2);
    @(posedge clk_i);
    idle_to_active_i         <= 1'b0;
    auto_return_idle_i       <= 1'b0;
    synth_calibrate_strobe_i <= 1'b0;
    #1 cal = synth_cal_start_o;
    if (which == 1) ret_n++;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_regs;
    chk("cfg reset value", reg_rdata_o, 8'h04);
    chk("ready high in reset", chip_ready_low_o, 1'b1);
    wr_reg(6'h18, 8'hFF);
    chk("cfg unused bits", reg_rdata_o, 8'h3F);
    chk("pin control on", pin_ctrl_en_o, 1'b1);
    wr_reg(6'h19, 8'h00);
    chk("cfg kept on other write", reg_rdata_o, 8'h3F);
    @(posedge clk_i);
    reg_addr_i    <= 6'h19;
    sleep_state_i <= 1'b1;
    #1 chk("other address reads zero", reg_rdata_o, 8'h00);
    chk("crystal kept in sleep", crystal_run_o, 1'b1);
    wr_reg(6'h18, 8'h3C);
    chk("pin control off", pin_ctrl_en_o, 1'b0);
    chk("crystal stops in sleep", crystal_run_o, 1'b0);
    @(posedge clk_i);
    sleep_state_i <= 1'b0;
    #1 chk("crystal runs awake", crystal_run_o, 1'b1);
  endtask

  task automatic test_autocal;
    logic cal;
    logic exp;
    for (int m = 0; m < 4; m++)
    begin
      wr_reg(6'h18, {2'b00, m[1:0], 4'h4});
      fire(0, cal);
      chk("cal leaving idle", cal, m == 1);
      exp = (m == 2) || (m == 3 && ret_n % 4 == 3);
      fire(1, cal);
      chk("cal on auto return", cal, exp);
      fire(2, cal);
      chk("cal on manual strobe", cal, 1'b1);
      @(posedge clk_i);
      #1 chk("cal pulse one cycle", synth_cal_start_o, 1'b0);
    end
    // back to back returns in mode 11: only every fourth calibrates
    for (int k = 0; k < 5; k++)
    begin
      exp = (ret_n % 4 == 3);
      fire(1, cal);
      chk("cal fourth return", cal, exp);
    end
  endtask

  // bounds allow a few cycles for the stable synchroniser and state hop
  task automatic power_on(input logic [1:0] sel, input int expiries);
    int n;
    n = 0;
    wr_reg(6'h18, {4'h0, sel, 2'b00});
    @(posedge clk_i);
    xtal_stable_i <= 1'b1;
    while (chip_ready_low_o !== 1'b0 && n < expiries * 64 + 20)
    begin
      @(posedge clk_i);
      #1 n++;
    end
    chk("ready not early", n >= expiries * 64, 1'b1);
    chk("ready not late", n <= expiries * 64 + 8, 1'b1);
    @(posedge clk_i);
    xtal_stable_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    #1 chk("ready drops with crystal", chip_ready_low_o, 1'b1);
  endtask

  // mid-run reset: register, ready and return count all start over
  task automatic test_reset;
    logic cal;
    wr_reg(6'h18, 8'h02);
    @(posedge clk_i);
    xtal_stable_i <= 1'b1;
    repeat (80) @(posedge clk_i);
    #1 chk("ready before reset", chip_ready_low_o, 1'b0);
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    #1 chk("cfg after reset", reg_rdata_o, 8'h04);
    chk("ready high on reset", chip_ready_low_o, 1'b1);
    chk("pin control on reset", pin_ctrl_en_o, 1'b0);
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    ret_n = 0;
    @(posedge clk_i);
    #1 chk("ready held after reset", chip_ready_low_o, 1'b1);
    wr_reg(6'h18, 8'h34);
    for (int k = 0; k < 4; k++)
    begin
      fire(1, cal);
      chk("cal fourth after reset", cal, k == 3);
    end
    @(posedge clk_i);
    xtal_stable_i <= 1'b0;
  endtask

  // ----------------------------------------
  // sequence, watchdog and verdict
  // ----------------------------------------
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    #1 test_regs;
    test_autocal;
    // select 0 runs with the crystal off until stable, select 2 is the robust pick
    for (int s = 0; s < 4; s++) power_on(s[1:0], exp_tab[s]);
    test_reset;
    test_done;
  end

  // whole run is about 22k cycles; allow 40k
  initial
  begin
    #4000000;
    fail_count++;
    test_done;
  end
endmodule
`default_nettype wire
